// >>> bench/bsnvm_assertions.sv
`timescale 1ns/1ps
module bsnvm_assertions #(
    parameter int PUMP_CYC = 4
) (
    input wire logic        i_clk,
    input wire logic        i_rst_b,
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [9:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    input wire logic        o_pump_ready,
    input wire logic        o_pump_clock_select,
    input wire logic        o_write_busy
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic tk = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire logic rs = o_wb_ack && !i_wb_we && i_wb_adr == bsnvm_pkg::STC_ADDR;
    AST_ACK_REQ: assert property (tk |=> o_wb_ack) else $error("ack late");
    AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack long");
    AST_BIT1_ZERO: assert property (rs |-> !o_wb_dat[1]) else $error("bit1 set");
    AST_DATA_MASK: assert property (rs && |o_wb_dat[5:2] |-> !o_wb_dat[7])
        else $error("data unmasked");
    AST_CLK_SEL: assert property (tk && i_wb_we && i_wb_sel[0]
        && i_wb_adr == bsnvm_pkg::STC_ADDR
        |-> ##2 o_pump_clock_select == $past(i_wb_dat[6], 2)) else $error("clk sel");
    AST_BUSY_PUMP: assert property (o_write_busy |-> o_pump_ready) else $error("busy");
    AST_PUMP_START: assert property ($rose(o_pump_ready)
        |-> !$past(o_pump_ready, PUMP_CYC - 1)) else $error("pump early");
    AST_RST_OUT: assert property ($rose(i_rst_b)
        |-> !o_pump_ready && !o_pump_clock_select) else $error("reset out");
endmodule

// >>> bench/bsnvm_bench.sv
`timescale 1ns/1ps
module bsnvm_bench;
    localparam logic [127:0] INIT = 128'h0123456789ABCDEFFEDCBA9876543211;
    localparam logic [9:0]   SEL  = bsnvm_pkg::SEL_ADDR;
    localparam logic [9:0]   STC  = bsnvm_pkg::STC_ADDR;
    logic         i_clk, i_rst_b, cyc, stb, we, rdy, pcs, busy, ack, tmo;
    logic [9:0]   adr;
    logic [3:0]   sel;
    logic [31:0]  dat, rdat;
    logic [127:0] mem;
    int           error_cnt, samples_checked;
    bsnvm_top #(.PUMP_CYC(4), .PGM_CYC(8), .INIT(INIT)) bsnvm_top_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .o_pump_ready(rdy), .o_pump_clock_select(pcs), .o_write_busy(busy));
    bsnvm_cpu bsnvm_cpu_i (.i_clk(i_clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc),
        .o_stb(stb), .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(dat), .o_tmo(tmo));
    task automatic complete_run;
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        bsnvm_cpu_i.xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] q;
        bsnvm_cpu_i.xfer(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic t_regs;
        rdc(SEL, 8'h00);
        rdc(STC, {INIT[0], 7'h01});
        wr(SEL, 8'hA5);
        rdc(SEL, 8'hA5);
        wr(STC, 8'h42);
        rdc(STC, {mem[37], 7'h40});
        chk({7'h00, pcs}, 8'h01);
        wr(STC, 8'h00);
        chk({7'h00, pcs}, 8'h00);
        wr(10'h000, 8'hFF);
        rdc(10'h000, 8'h00);
    endtask
    task automatic t_walk;
        for (int i = 127; i >= 0; i--) begin
            wr(SEL, 8'(i));
            rdc(STC, {mem[i], 6'h00, i[2:0] == 3'h0});
        end
    endtask
    task automatic t_op(input logic [7:0] s, input logic [7:0] c);
        int n;
        wr(SEL, s);
        wr(STC, c);
        n = 0;
        while (rdy !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            n++;
        end
        chk({7'h00, rdy}, 8'h01);
        repeat (12) @(posedge i_clk);
        chk({7'h00, busy}, 8'h01);
        rdc(STC, {1'b0, c[6:0] | {6'h00, s[2:0] == 3'h0}});
        wr(STC, c & 8'hDF);
        chk({7'h00, rdy}, 8'h01);
        wr(STC, 8'h00);
        repeat (2) @(posedge i_clk);
        chk({7'h00, rdy}, 8'h00);
        chk({7'h00, busy}, 8'h00);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    always @(posedge tmo) begin
        error_cnt++;
        complete_run();
    end
    initial begin
        error_cnt = 0;
        samples_checked = 0;
        mem = INIT;
        i_rst_b = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        t_regs();
        t_walk();
        t_op(8'h2B, 8'h24);
        wr(SEL, 8'h2B);
        rdc(STC, 8'h80);
        mem[43] = 1'b1;
        t_op(8'h28, 8'h28);
        mem[47:40] = 8'h00;
        t_walk();
        t_op(8'h00, 8'h38);
        mem = '0;
        t_walk();
        complete_run();
    end
endmodule
bind bsnvm_top bsnvm_assertions #(.PUMP_CYC(PUMP_CYC)) bsnvm_assertions_i (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .o_pump_ready(o_pump_ready),
    .o_pump_clock_select(o_pump_clock_select), .o_write_busy(o_write_busy));

// >>> bench/bsnvm_cpu.sv
`timescale 1ns/1ps
module bsnvm_cpu (
    input  wire logic        i_clk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_rdat,
    output logic             o_cyc,
    output logic             o_stb,
    output logic             o_we,
    output logic [9:0]       o_adr,
    output logic [3:0]       o_sel,
    output logic [31:0]      o_dat,
    output logic             o_tmo
);
    initial begin
        o_cyc = 1'b0;
        o_stb = 1'b0;
        o_we  = 1'b0;
        o_adr = 10'h000;
        o_sel = 4'h1;
        o_dat = 32'h00000000;
        o_tmo = 1'b0;
    end
    // one classic cycle, then one idle cycle with released lines inverted
    task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        n = 0;
        o_cyc <= 1'b1;
        o_stb <= 1'b1;
        o_we  <= w;
        o_adr <= a;
        o_dat <= {24'h000000, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (i_ack !== 1'b1 && n < 40);
        q = i_rdat[7:0];
        o_tmo <= (n >= 40);
        o_cyc <= 1'b0;
        o_stb <= 1'b0;
        o_we  <= ~w;
        o_adr <= ~a;
        o_dat <= ~o_dat;
        @(posedge i_clk);
    endtask
endmodule

// >>> logic/bsnvm_pkg.sv
package bsnvm_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets scaled from word indices)
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_IDX      = 8'h0E;
    localparam logic [7:0] STC_IDX      = 8'h0F;
    localparam logic [9:0] SEL_ADDR     = 10'h038;
    localparam logic [9:0] STC_ADDR     = 10'h03C;

    // ------------------------------------------------------------
    // status/control bit positions
    // ------------------------------------------------------------
    localparam int COLZ_BIT   = 0;
    localparam int PGM_BIT    = 2;
    localparam int BYTE_BIT   = 3;
    localparam int BULK_BIT   = 4;
    localparam int PEN_BIT    = 5;
    localparam int PCLK_BIT   = 6;
    localparam int DATA_BIT   = 7;

    // ------------------------------------------------------------
    // reset values and geometry
    // ------------------------------------------------------------
    localparam logic [7:0]   SEL_RST     = 8'h00;
    localparam int           ROWS        = 16;
    localparam int           COLS        = 8;
    localparam logic [127:0] ARRAY_RST   = 128'h0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int PUMP_START_NS  = 1000;
    localparam int PROGRAM_NS     = 4000;
    localparam int PUMP_START_CYC = (PUMP_START_NS * CLK_MHZ + 999) / 1000;
    localparam int PROGRAM_CYC    = (PROGRAM_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        PUMP_OFF   = 2'b00,
        PUMP_START = 2'b01,
        PUMP_RUN   = 2'b10
    } bsnvm_pump_t;

    typedef struct packed {
        logic [7:0] sel;
        logic       pump_clock_select;
        logic       pump_enable;
        logic       row_erase;
        logic       cell_program;
        logic       array_erase;
    } bsnvm_ctl_t;

    typedef struct packed {
        bsnvm_ctl_t   ctl;
        logic [127:0] cells;
        bsnvm_pump_t  pump;
        logic [15:0]  pcnt;
        logic [15:0]  wcnt;
        logic         ack;
        logic [31:0]  rdat;
        logic         ready;
        logic         busy;
        logic         data;
    } bsnvm_state_t;

endpackage

// >>> logic/bsnvm_top.sv
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
// Function
// - sixteen rows, eight columns, one sense amplifier
// - select bits 6:3 row, 2:0 column
// - select bit 7 spare storage, reset clears
// - select register reads back last write
// - status bit 1 reads zero
// - reset: column flag set, data shows bit 0
// - column flag tracks column zero selection
// - increment past column seven enters next row
// - pump clock select bit, bus or ring
// - pump starts with enable plus program/erase
// - pump runs until all four bits clear
// - data bit follows sense, valid when idle
// - program writes one into selected cell
// - row erase clears selected row
// - bulk erase clears entire array
// - row plus bulk erase means bulk
module bsnvm_top #(
    parameter int            PUMP_CYC = bsnvm_pkg::PUMP_START_CYC,
    parameter int            PGM_CYC  = bsnvm_pkg::PROGRAM_CYC,
    parameter logic [127:0]  INIT     = bsnvm_pkg::ARRAY_RST
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [9:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_pump_ready,
    output logic             o_pump_clock_select,
    output logic             o_write_busy
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    bsnvm_pkg::bsnvm_state_t st_r;
    bsnvm_pkg::bsnvm_state_t st_nxt;
    logic                    init_done_r;

    // ------------------------------------------------------------
    // select decoding
    // ------------------------------------------------------------
    // row number from the select value
    function automatic logic [3:0] row_of(
        input logic [7:0] sel
    );
        row_of = sel[6:3];
    endfunction

    // column number from the select value
    function automatic logic [2:0] col_of(
        input logic [7:0] sel
    );
        col_of = sel[2:0];
    endfunction

    // array cell addressed by the select value, bit 7 ignored
    function automatic logic [6:0] cell_idx(
        input logic [7:0] sel
    );
        cell_idx = {row_of(sel), col_of(sel)};
    endfunction

    // column zero of any row selected
    function automatic logic col_zero(
        input logic [7:0] sel
    );
        col_zero = (col_of(sel) == 3'h0);
    endfunction

    // ------------------------------------------------------------
    // control decoding
    // ------------------------------------------------------------
    // any program or erase request
    function automatic logic any_op(
        input bsnvm_pkg::bsnvm_ctl_t c
    );
        any_op = c.cell_program | c.row_erase | c.array_erase;
    endfunction

    // any of the four control bits set
    function automatic logic any_ctl(
        input bsnvm_pkg::bsnvm_ctl_t c
    );
        any_ctl = c.pump_enable | any_op(c);
    endfunction

    // all four control bits clear: the pump may stop
    function automatic logic pump_idle(
        input bsnvm_pkg::bsnvm_ctl_t c
    );
        pump_idle = ~any_ctl(c);
    endfunction

    // pump has run for its whole startup time
    function automatic logic start_done(
        input logic [15:0] n
    );
        start_done = (n >= 16'(PUMP_CYC - 1));
    endfunction

    // cells have seen the voltage for the whole programming time
    function automatic logic hold_done(
        input logic [15:0] n
    );
        hold_done = (n >= 16'(PGM_CYC - 1));
    endfunction

    // control bits taken from a written status byte
    function automatic bsnvm_pkg::bsnvm_ctl_t ctl_write(
        input bsnvm_pkg::bsnvm_ctl_t c,
        input logic [7:0]            b
    );
        bsnvm_pkg::bsnvm_ctl_t n;
        n                   = c;
        n.pump_clock_select = b[bsnvm_pkg::PCLK_BIT];
        n.pump_enable       = b[bsnvm_pkg::PEN_BIT];
        n.array_erase       = b[bsnvm_pkg::BULK_BIT];
        n.row_erase         = b[bsnvm_pkg::BYTE_BIT];
        n.cell_program      = b[bsnvm_pkg::PGM_BIT];
        ctl_write           = n;
    endfunction

    // status/control read value
    function automatic logic [7:0] stc_read(
        input bsnvm_pkg::bsnvm_state_t s
    );
        logic [7:0] v;
        v                      = 8'h00;
        v[bsnvm_pkg::DATA_BIT] = s.data;
        v[bsnvm_pkg::PCLK_BIT] = s.ctl.pump_clock_select;
        v[bsnvm_pkg::PEN_BIT]  = s.ctl.pump_enable;
        v[bsnvm_pkg::BULK_BIT] = s.ctl.array_erase;
        v[bsnvm_pkg::BYTE_BIT] = s.ctl.row_erase;
        v[bsnvm_pkg::PGM_BIT]  = s.ctl.cell_program;
        v[bsnvm_pkg::COLZ_BIT] = col_zero(s.ctl.sel);
        stc_read               = v;
    endfunction

    // read value of the addressed register, zero when unmapped
    function automatic logic [31:0] bus_read(
        input bsnvm_pkg::bsnvm_state_t s,
        input logic                    a_sel,
        input logic                    a_stc
    );
        if (a_sel) begin
            bus_read = {24'h000000, s.ctl.sel};
        end else if (a_stc) begin
            bus_read = {24'h000000, stc_read(s)};
        end else begin
            bus_read = 32'h00000000;
        end
    endfunction

    // ------------------------------------------------------------
    // array operations
    // ------------------------------------------------------------
    // clear the eight cells of one row
    function automatic logic [127:0] row_clear(
        input logic [127:0] m,
        input logic [3:0]   r
    );
        logic [127:0] n;
        n = m;
        for (int c = 0; c < bsnvm_pkg::COLS; c++) begin
            n[{r, 3'(c)}] = 1'b0;
        end
        row_clear = n;
    endfunction

    // set one cell
    function automatic logic [127:0] cell_set(
        input logic [127:0] m,
        input logic [6:0]   i
    );
        logic [127:0] n;
        n        = m;
        n[i]     = 1'b1;
        cell_set = n;
    endfunction

    // sense amplifier output, held low while voltage may be applied
    function automatic logic sense(
        input logic [127:0]          m,
        input bsnvm_pkg::bsnvm_ctl_t c
    );
        if (any_ctl(c)) begin
            sense = 1'b0;
        end else begin
            sense = m[cell_idx(c.sel)];
        end
    endfunction

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       req;
    logic       hit_sel;
    logic       hit_stc;
    logic       wr_en;
    logic       wr_sel;
    logic       wr_stc;
    logic [7:0] wbyte;
    logic [3:0] row;

    assign req     = i_wb_cyc & i_wb_stb & ~st_r.ack;
    assign hit_sel = (i_wb_adr == bsnvm_pkg::SEL_ADDR);
    assign hit_stc = (i_wb_adr == bsnvm_pkg::STC_ADDR);
    assign wr_en   = req & i_wb_we & i_wb_sel[0];
    assign wr_sel  = wr_en & hit_sel;
    assign wr_stc  = wr_en & hit_stc;
    assign wbyte   = i_wb_dat[7:0];
    assign row     = row_of(st_r.ctl.sel);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt     = st_r;
        st_nxt.ack = req;
        if (req) begin
            st_nxt.rdat = bus_read(st_r, hit_sel, hit_stc);
        end

        // --------------------------------------------------------
        // register writes
        // --------------------------------------------------------
        if (wr_sel) begin
            st_nxt.ctl.sel = wbyte;
        end
        if (wr_stc) begin
            st_nxt.ctl = ctl_write(st_nxt.ctl, wbyte);
        end

        // --------------------------------------------------------
        // pump sequencing
        // --------------------------------------------------------
        case (st_r.pump)
            bsnvm_pkg::PUMP_OFF: begin
                st_nxt.pcnt = 16'h0000;
                if (st_r.ctl.pump_enable && any_op(st_r.ctl)) begin
                    st_nxt.pump = bsnvm_pkg::PUMP_START;
                end
            end
            bsnvm_pkg::PUMP_START: begin
                st_nxt.pcnt = st_r.pcnt + 16'h0001;
                if (pump_idle(st_r.ctl)) begin
                    st_nxt.pump = bsnvm_pkg::PUMP_OFF;
                end else if (start_done(st_r.pcnt)) begin
                    st_nxt.pump = bsnvm_pkg::PUMP_RUN;
                end
            end
            bsnvm_pkg::PUMP_RUN: begin
                if (pump_idle(st_r.ctl)) begin
                    st_nxt.pump = bsnvm_pkg::PUMP_OFF;
                end
            end
            default: begin
                st_nxt.pump = bsnvm_pkg::PUMP_OFF;
            end
        endcase
        st_nxt.ready = (st_nxt.pump == bsnvm_pkg::PUMP_RUN);

        // --------------------------------------------------------
        // cell writing while voltage is present
        // --------------------------------------------------------
        st_nxt.busy = 1'b0;
        if (st_r.pump == bsnvm_pkg::PUMP_RUN && any_op(st_r.ctl)) begin
            st_nxt.busy = 1'b1;
            if (hold_done(st_r.wcnt)) begin
                if (st_r.ctl.array_erase) begin
                    st_nxt.cells = 128'h0;
                end else if (st_r.ctl.row_erase) begin
                    st_nxt.cells = row_clear(st_r.cells, row);
                end else begin
                    st_nxt.cells = cell_set(st_r.cells, cell_idx(st_r.ctl.sel));
                end
            end else begin
                st_nxt.wcnt = st_r.wcnt + 16'h0001;
            end
        end else begin
            st_nxt.wcnt = 16'h0000;
        end

        // --------------------------------------------------------
        // sense amplifier
        // --------------------------------------------------------
        st_nxt.data = sense(st_nxt.cells, st_nxt.ctl);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            st_r.ctl.sel               <= bsnvm_pkg::SEL_RST;
            st_r.ctl.pump_clock_select <= 1'b0;
            st_r.ctl.pump_enable       <= 1'b0;
            st_r.ctl.row_erase         <= 1'b0;
            st_r.ctl.cell_program      <= 1'b0;
            st_r.ctl.array_erase       <= 1'b0;
            st_r.pump                  <= bsnvm_pkg::PUMP_OFF;
            st_r.pcnt                  <= 16'h0000;
            st_r.wcnt                  <= 16'h0000;
            st_r.ack                   <= 1'b0;
            st_r.rdat                  <= 32'h00000000;
            st_r.ready                 <= 1'b0;
            st_r.busy                  <= 1'b0;
            if (init_done_r) begin
                st_r.cells <= st_r.cells;
                st_r.data  <= st_r.cells[0];
            end else begin
                st_r.cells <= INIT;
                st_r.data  <= INIT[0];
            end
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // first reset loads the array contents, later ones keep them
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        init_done_r <= init_done_r | ~i_rst_b;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_wb_dat            = st_r.rdat;
    assign o_wb_ack            = st_r.ack;
    assign o_pump_ready        = st_r.ready;
    assign o_pump_clock_select = st_r.ctl.pump_clock_select;
    assign o_write_busy        = st_r.busy;

endmodule
